// ==== hw/dplr_ram.sv ====
// Dual-port 32 x 4 latch RAM block with synchronous or asynchronous write.
// Assumes all inputs are synchronous to CORE_CLK, which stands for the sector clock.
// Contract
// - Thirty-two four-bit nibbles, separate data in/out.
// - Write data input is four bits.
// - Five-bit read address, independent of write.
// - Reads never stalled by write activity.
// - Read path is purely combinational.
// - Front latch passes at load one.
// - Synchronous mode latches address, strobe, data.
// - Front and storage latch form flip-flop.
// - Nibble written only when addressed, loaded, strobed.
// - Both clock selectors switch together.
// - Uses the adjoining sector-column clock.
// - Single-port: write address, bidirectional data.
// - Rightmost instance is single-port only.
// - Configuration clear empties every nibble.
// - Sector clock true, inverted or off.
`timescale 1ns/1ps
module dplr_ram
   import dplr_pkg::*;
#(
   parameter bit RIGHTMOST = 1'b0 // Block sits in the rightmost column.
) (
   input wire logic CORE_CLK, // Sector-column clock source.
   input wire logic RESETN, // Asynchronous reset, active low.
   input wire logic SYNC_MODE, // High for synchronous write.
   input wire dplr_sclk_t SECTOR_CLK_SEL, // Sector clock true, inverted or off.
   input wire logic SINGLE_PORT, // High for single-port use.
   input wire logic CONFIG_CLEAR, // Configuration write to the clear location.
   input wire logic [4:0] WRITE_ADDR, // Write address.
   input wire logic WRITE_STROBE_N, // Write strobe, active low.
   input wire logic [3:0] DIN, // Write data, also data pin level in single-port use.
   output logic [3:0] DIN_OUT, // Read data driven back on the data pins.
   output logic DIN_OE, // Data pins driven by the block.
   input wire logic [4:0] READ_ADDR, // Read address.
   input wire logic OUTPUT_DRIVE_LOW_N, // Output enable, active low.
   output logic [3:0] DOUT_DATA, // Read data.
   output logic DOUT_OE // Read data driven.
);

   // Front-end stage in synchronous mode.
   logic [4:0] fe_addr_ff;
   logic fe_we_n_ff;
   logic [3:0] fe_data_ff;
   logic [4:0] nxt_fe_addr;
   logic nxt_fe_we_n;
   logic [3:0] nxt_fe_data;

   // Sector clock live
   // The block borrows the clock of the sector column up and to its left.
   wire sclk_live;
   // Clock select decode
   // Inverted and true select act alike at cycle level; off stops every load in synchronous mode only.
   assign sclk_live = (SECTOR_CLK_SEL != DPLR_SCLK_OFF);

   // Shared selector load
   // Both selectors follow the one mode bit; asynchronous mode holds load at one.
   wire load_front;
   wire load_store;
   assign load_front = SYNC_MODE ? sclk_live : 1'b1;
   assign load_store = SYNC_MODE ? sclk_live : 1'b1;

   assign nxt_fe_addr = load_front ? WRITE_ADDR : fe_addr_ff;
   assign nxt_fe_we_n = load_front ? WRITE_STROBE_N : fe_we_n_ff;
   assign nxt_fe_data = load_front ? DIN : fe_data_ff;

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         fe_addr_ff <= DPLR_ADDR_RST;
         fe_we_n_ff <= DPLR_WE_N_RST;
         fe_data_ff <= DPLR_WORD_RST;
      end else begin
         fe_addr_ff <= nxt_fe_addr;
         fe_we_n_ff <= nxt_fe_we_n;
         fe_data_ff <= nxt_fe_data;
      end
   end

   // Latched write inputs
   // Synchronous mode writes from the front stage, one edge behind the pins.
   wire [4:0] wr_addr;
   wire wr_we_n;
   wire [3:0] wr_data;
   assign wr_addr = SYNC_MODE ? fe_addr_ff : WRITE_ADDR;
   assign wr_we_n = SYNC_MODE ? fe_we_n_ff : WRITE_STROBE_N;
   assign wr_data = SYNC_MODE ? fe_data_ff : DIN;

   logic [3:0] words [DPLR_DEPTH];
   wire [DPLR_DEPTH*DPLR_DW-1:0] mem_flat;

   genvar gi;
   generate
      for (gi = 0; gi < DPLR_DEPTH; gi++) begin : g_word
         wire sel_load;
         assign sel_load = (wr_addr == 5'(gi)) && load_store && !wr_we_n;
         dplr_nibble u_nibble (
            .clk(CORE_CLK),
            .rst_n(RESETN),
            .clear(CONFIG_CLEAR),
            .load(sel_load),
            .d(wr_data),
            .q(words[gi])
         );
         assign mem_flat[gi*DPLR_DW +: DPLR_DW] = words[gi];
      end
   endgenerate

   wire single_eff;
   assign single_eff = RIGHTMOST || SINGLE_PORT;

   wire [4:0] rd_addr;
   assign rd_addr = single_eff ? WRITE_ADDR : READ_ADDR;

   wire [3:0] rd_data;
   assign rd_data = words[rd_addr];

   assign DOUT_DATA = rd_data;
   assign DOUT_OE = !OUTPUT_DRIVE_LOW_N;

   // Bidirectional data pins
   // Pins turn around only while no write is asked, so the party's drive never clashes.
   assign DIN_OUT = rd_data;
   assign DIN_OE = single_eff && !OUTPUT_DRIVE_LOW_N && WRITE_STROBE_N;

   // Checks.
   property p_async_write_read;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (!SYNC_MODE && !WRITE_STROBE_N && !CONFIG_CLEAR && !single_eff && (READ_ADDR == WRITE_ADDR))
      ##1 (READ_ADDR == $past(READ_ADDR)) |-> (DOUT_DATA == $past(DIN));
   endproperty
   a_async_write_read: assert property (p_async_write_read) else $error("Async write not seen on read");

   property p_sync_two_stage;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (SYNC_MODE && sclk_live && !WRITE_STROBE_N && !CONFIG_CLEAR)
      ##1 (SYNC_MODE && sclk_live && !CONFIG_CLEAR)
      |=> (words[$past(WRITE_ADDR, 2)] == $past(DIN, 2));
   endproperty
   a_sync_two_stage: assert property (p_sync_two_stage) else $error("Sync write not stored after two edges");

   property p_sync_delay;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (SYNC_MODE && sclk_live && !CONFIG_CLEAR && $past(SYNC_MODE) && $past(sclk_live) && $past(WRITE_STROBE_N))
      |=> $stable(mem_flat);
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("Sync write skipped front stage");

   property p_clear;
      @(posedge CORE_CLK) disable iff (!RESETN)
      CONFIG_CLEAR |=> (mem_flat == '0);
   endproperty
   a_clear: assert property (p_clear) else $error("Clear left data behind");

   property p_clk_off_hold;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (SYNC_MODE && (SECTOR_CLK_SEL == DPLR_SCLK_OFF) && !CONFIG_CLEAR) |=> $stable(mem_flat);
   endproperty
   a_clk_off_hold: assert property (p_clk_off_hold) else $error("Write with sector clock off");

   property p_strobe_high_hold;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (!SYNC_MODE && WRITE_STROBE_N && !CONFIG_CLEAR) |=> $stable(mem_flat);
   endproperty
   a_strobe_high_hold: assert property (p_strobe_high_hold) else $error("Write without strobe");

   property p_selectors_together;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (!SYNC_MODE || sclk_live)
      |=> (fe_addr_ff == $past(WRITE_ADDR)) && (fe_we_n_ff == $past(WRITE_STROBE_N)) && (fe_data_ff == $past(DIN));
   endproperty
   a_selectors_together: assert property (p_selectors_together) else $error("Front stage missed an open load");

   property p_front_hold;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (SYNC_MODE && !sclk_live) |=> ($stable(fe_addr_ff) && $stable(fe_we_n_ff) && $stable(fe_data_ff));
   endproperty
   a_front_hold: assert property (p_front_hold) else $error("Front stage moved with load low");

   property p_oe_float;
      @(posedge CORE_CLK) disable iff (!RESETN)
      OUTPUT_DRIVE_LOW_N |-> (!DOUT_OE && !DIN_OE);
   endproperty
   a_oe_float: assert property (p_oe_float) else $error("Output driven while disabled");

   property p_read_indep;
      @(posedge CORE_CLK) disable iff (!RESETN)
      ($stable(mem_flat) && $stable(rd_addr)) |-> $stable(DOUT_DATA);
   endproperty
   a_read_indep: assert property (p_read_indep) else $error("Read moved without cause");

   property p_single_port;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (single_eff && !SYNC_MODE && !WRITE_STROBE_N && !CONFIG_CLEAR)
      ##1 (WRITE_ADDR == $past(WRITE_ADDR)) |-> (DIN_OUT == $past(DIN));
   endproperty
   a_single_port: assert property (p_single_port) else $error("Single-port read misses write");

   property p_rightmost;
      @(posedge CORE_CLK) disable iff (!RESETN)
      RIGHTMOST |-> (DOUT_DATA == words[WRITE_ADDR]);
   endproperty
   a_rightmost: assert property (p_rightmost) else $error("Rightmost block read its read address");

   c_sync_write: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
      SYNC_MODE && sclk_live && !WRITE_STROBE_N ##2 DOUT_OE);
   c_sclk_off_write: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
      SYNC_MODE && !sclk_live && !WRITE_STROBE_N);
   c_async_write: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
      !SYNC_MODE && !WRITE_STROBE_N ##1 DOUT_OE);
   c_clear: cover property (@(posedge CORE_CLK) disable iff (!RESETN) CONFIG_CLEAR ##1 DOUT_OE);
   c_single_read: cover property (@(posedge CORE_CLK) disable iff (!RESETN) DIN_OE);

endmodule : dplr_ram

// ==== hw/dplr_pkg.sv ====
// Package for the dual-port latch RAM: sizes, reset values, sector clock choices.
// Assumes one core clock and an active-low asynchronous reset in every user.
package dplr_pkg;

   // Array shape: 32 nibbles of 4 bits.
   localparam int unsigned DPLR_DEPTH = 32;
   localparam int unsigned DPLR_AW = 5;
   localparam int unsigned DPLR_DW = 4;

   // Core clock figure, kept for timing reference only.
   localparam int unsigned DPLR_CLK_PERIOD_NS = 40;

   // Values after reset; the nibble value also after a configuration clear.
   localparam logic [3:0] DPLR_WORD_RST = 4'h0;
   localparam logic [4:0] DPLR_ADDR_RST = 5'h00;
   localparam logic DPLR_WE_N_RST = 1'b1;

   // Sector clock selection.
   typedef enum logic [1:0] {
      DPLR_SCLK_OFF,
      DPLR_SCLK_TRUE,
      DPLR_SCLK_INV
   } dplr_sclk_t;

endpackage : dplr_pkg

// ==== hw/dplr_nibble.sv ====
// One stored nibble of the latch RAM.
// Assumes the caller decodes load from address, strobe and load phase.
`timescale 1ns/1ps
module dplr_nibble
   import dplr_pkg::*;
(
   input wire logic clk, // Core clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic clear, // Configuration clear, wins over load.
   input wire logic load, // Open this nibble to the write data.
   input wire logic [3:0] d, // Write data.
   output logic [3:0] q // Stored nibble.
);

   logic [3:0] word_ff;
   logic [3:0] nxt_word;

   assign nxt_word = clear ? DPLR_WORD_RST : (load ? d : word_ff);
   assign q = word_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_ff <= DPLR_WORD_RST;
      end else begin
         word_ff <= nxt_word;
      end
   end

endmodule : dplr_nibble

// ==== verif/dplr_user.sv ====
// Far-side user logic that shares the data pins with the latch RAM.
// Assumes the bench sets its drive value and enable at the clock edge.
`timescale 1ns/1ps
module dplr_user (
   input wire logic clk, // Core clock.
   input wire logic [3:0] usr_drv, // Value the user logic puts on the pins.
   input wire logic usr_en, // User logic drives the pins.
   input wire logic [3:0] ram_drv, // Value the block drives back.
   input wire logic ram_en, // Block drives the pins.
   output logic [3:0] pin // Resolved pin level.
);
   logic [3:0] last_ff;
   assign pin = (usr_en && ram_en) ? 4'hx : usr_en ? usr_drv : ram_en ? ram_drv : ~last_ff;
   // Undriven pins drift away from the last driven value.
   always_ff @(posedge clk) begin
      if (usr_en || ram_en) begin
         last_ff <= pin;
      end
   end
endmodule : dplr_user

// ==== verif/dual_port_latch_ram_32x4_tb.sv ====
// Self-checking bench for the latch RAM with user logic on the data pins.
// Assumes the assertions inside the block watch its own timing.
`timescale 1ns/1ps
module dual_port_latch_ram_32x4_tb;
   import dplr_pkg::*;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic sync_mode = 1'b0;
   dplr_sclk_t sclk_sel = DPLR_SCLK_TRUE;
   logic single_port = 1'b0;
   logic cfg_clear = 1'b0;
   logic [4:0] wr_addr = 5'h00;
   logic wr_strobe_n = 1'b1;
   logic [4:0] rd_addr = 5'h00;
   logic oe_n = 1'b0;
   logic [3:0] usr_drv = 4'h0;
   logic usr_en = 1'b1;
   logic [3:0] din_pin, din_out, dout_data;
   logic din_oe, dout_oe;
   logic [3:0] edge_dout;
   int mismatches = 0;
   int tests_run = 0;

   dplr_ram i_dut (.CORE_CLK(core_clk), .RESETN(resetn), .SYNC_MODE(sync_mode), .SECTOR_CLK_SEL(sclk_sel),
      .SINGLE_PORT(single_port), .CONFIG_CLEAR(cfg_clear), .WRITE_ADDR(wr_addr), .WRITE_STROBE_N(wr_strobe_n),
      .DIN(din_pin), .DIN_OUT(din_out), .DIN_OE(din_oe), .READ_ADDR(rd_addr), .OUTPUT_DRIVE_LOW_N(oe_n),
      .DOUT_DATA(dout_data), .DOUT_OE(dout_oe));
   dplr_user i_user (.clk(core_clk), .usr_drv(usr_drv), .usr_en(usr_en), .ram_drv(din_out), .ram_en(din_oe),
      .pin(din_pin));
   // A rightmost copy sees the same traffic and must always read at the write address.
   dplr_ram #(.RIGHTMOST(1'b1)) i_dut_edge (.CORE_CLK(core_clk), .RESETN(resetn), .SYNC_MODE(sync_mode),
      .SECTOR_CLK_SEL(sclk_sel), .SINGLE_PORT(single_port), .CONFIG_CLEAR(cfg_clear), .WRITE_ADDR(wr_addr),
      .WRITE_STROBE_N(wr_strobe_n), .DIN(din_pin), .DIN_OUT(), .DIN_OE(), .READ_ADDR(rd_addr),
      .OUTPUT_DRIVE_LOW_N(oe_n), .DOUT_DATA(edge_dout), .DOUT_OE());

   initial begin
      forever #20 core_clk = ~core_clk;
   end

   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [3:0] d);
      @(posedge core_clk);
      wr_addr <= a;
      usr_drv <= d;
      wr_strobe_n <= 1'b0;
      @(posedge core_clk);
      wr_strobe_n <= 1'b1;
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [3:0] e);
      @(posedge core_clk);
      rd_addr <= a;
      #1;
      chk(dout_data, e);
   endtask : rd

   task automatic all_zero;
      for (int i = 0; i < 32; i++) rd(i[4:0], 4'h0);
   endtask : all_zero

   task automatic async_fill;
      for (int i = 0; i < 32; i++) wr(i[4:0], i[3:0] ^ 4'h5);
      for (int i = 0; i < 32; i++) rd(i[4:0], i[3:0] ^ 4'h5);
      rd(5'h00, 4'h5);
      chk(edge_dout, 4'ha);
   endtask : async_fill

   task automatic sync_write(input dplr_sclk_t s, input logic [4:0] a, input logic [3:0] d, input logic [3:0] o);
      @(posedge core_clk);
      sync_mode <= 1'b1;
      sclk_sel <= s;
      rd(a, o);
      wr(a, d);
      #1;
      chk(dout_data, o);
      @(posedge core_clk);
      sclk_sel <= DPLR_SCLK_TRUE;
      #1;
      chk(dout_data, (s == DPLR_SCLK_OFF) ? o : d);
      repeat (2) @(posedge core_clk);
      #1;
      chk(dout_data, (s == DPLR_SCLK_OFF) ? o : d);
   endtask : sync_write

   task automatic single_use;
      @(posedge core_clk);
      sync_mode <= 1'b0;
      single_port <= 1'b1;
      usr_en <= 1'b0;
      wr_addr <= 5'h03;
      rd_addr <= 5'h09;
      #1;
      chk(din_pin, 4'ha);
      chk(dout_data, 4'ha);
      chk({3'b000, din_oe}, 4'h1);
      @(posedge core_clk);
      oe_n <= 1'b1;
      usr_en <= 1'b1;
      #1;
      chk({3'b000, dout_oe}, 4'h0);
      wr(5'h07, 4'h9);
      @(posedge core_clk);
      usr_en <= 1'b0;
      oe_n <= 1'b0;
      #1;
      chk(din_pin, 4'h9);
      chk({3'b000, dout_oe}, 4'h1);
      @(posedge core_clk);
      usr_en <= 1'b1;
      single_port <= 1'b0;
   endtask : single_use

   task automatic clear_all;
      @(posedge core_clk);
      cfg_clear <= 1'b1;
      wr_addr <= 5'h02;
      usr_drv <= 4'hf;
      wr_strobe_n <= 1'b0;
      @(posedge core_clk);
      cfg_clear <= 1'b0;
      wr_strobe_n <= 1'b1;
      all_zero();
   endtask : clear_all

   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      #(40 * 2000);
      mismatches++;
      close_out();
   end

   initial begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      all_zero();
      async_fill();
      sync_write(DPLR_SCLK_TRUE, 5'h03, 4'ha, 4'h6);
      sync_write(DPLR_SCLK_INV, 5'h04, 4'hb, 4'h1);
      sync_write(DPLR_SCLK_OFF, 5'h05, 4'hc, 4'h0);
      single_use();
      clear_all();
      close_out();
   end
endmodule : dual_port_latch_ram_32x4_tb
